// >>> verilog/hpcs_regs.vh
`ifndef HPCS_REGS_VH
`define HPCS_REGS_VH
// ----------------------------------------------------------------------
// Configuration select decode
// ----------------------------------------------------------------------
`define HPCS_DEV_FIRST 5'h05
`define HPCS_DEV_LAST 5'h0A
`define HPCS_IDSEL_COUNT 6
`define HPCS_IDSEL_BASE_LINE 21
`define HPCS_DEV_TO_LINE 16
// ----------------------------------------------------------------------
// Arbiter
// ----------------------------------------------------------------------
`define HPCS_REQ_COUNT 3
`define HPCS_REQ_FAST_NIC 0
`define HPCS_REQ_HOME_NIC 1
`define HPCS_REQ_EXPANSION 2
// ----------------------------------------------------------------------
// Sideband link and timing
// ----------------------------------------------------------------------
`define HPCS_SB_LSB 2
`define HPCS_SB_MSB 17
`define HPCS_SB_WIDTH 16
`define HPCS_CLK_MHZ 40
`define HPCS_PCI_MHZ 33
`define HPCS_FLOAT_NS 50
`define HPCS_FLOAT_CYC ((`HPCS_FLOAT_NS * `HPCS_CLK_MHZ + 999) / 1000)
`endif

// >>> verilog/hpcs_top.v
// Function
// - Configuration access to devices 5 to 10 drives exactly one of six ID select lines.
// - Devices 5 to 10 select address lines 21 to 26 (line minus 16).
// - Bus side runs 33 MHz revision 2.0 signalling at 5 V.
// - Arbiter offers three request/grant pairs: two NICs, one expansion.
// - Sideband link rides CPU address pins 2 to 17, no own pins.
// - Assert CPU address hold while link runs; CPU floats its address.
// - Home NIC irq on line a, fast NIC irq on line b.
`timescale 1ns/1ps
`include "hpcs_regs.vh"
module hpcs_top #(
	parameter DEV_W = 5,
	parameter FLOAT_CYC = `HPCS_FLOAT_CYC
)(
	clk_sys,
	sys_rst,
	cfg_access,
	cfg_dev_num,
	id_select,
	pci_req,
	pci_bus_idle,
	pci_gnt,
	home_nic_irq,
	fast_nic_irq,
	pci_irq_line_a,
	pci_irq_line_b,
	sb_request,
	sb_wdata,
	sb_write,
	sb_done,
	cpu_addr_in,
	sb_rdata,
	cpu_address_hold,
	sb_addr_out,
	sb_addr_oe,
	sb_busy
);
	input wire clk_sys;
	input wire sys_rst;
	input wire cfg_access;
	input wire [DEV_W-1:0] cfg_dev_num;
	output reg [`HPCS_IDSEL_COUNT-1:0] id_select;
	input wire [`HPCS_REQ_COUNT-1:0] pci_req;
	input wire pci_bus_idle;
	output reg [`HPCS_REQ_COUNT-1:0] pci_gnt;
	input wire home_nic_irq;
	input wire fast_nic_irq;
	output reg pci_irq_line_a;
	output reg pci_irq_line_b;
	input wire sb_request;
	input wire [`HPCS_SB_WIDTH-1:0] sb_wdata;
	input wire sb_write;
	input wire sb_done;
	input wire [`HPCS_SB_MSB:`HPCS_SB_LSB] cpu_addr_in;
	output reg [`HPCS_SB_WIDTH-1:0] sb_rdata;
	output reg cpu_address_hold;
	output reg [`HPCS_SB_MSB:`HPCS_SB_LSB] sb_addr_out;
	output reg sb_addr_oe;
	output reg sb_busy;

	// ------------------------------------------------------------------
	// Configuration select decode
	// ------------------------------------------------------------------
	// One-hot select; devices outside 5..10 select nothing.
	// The bus side timing (33 MHz, rev 2.0, 5 V) lives in the pad ring.
	reg [`HPCS_IDSEL_COUNT-1:0] id_select_next;
	integer k;
	always @*
	begin
		id_select_next = {`HPCS_IDSEL_COUNT{1'b0}};
		for (k = 0; k < `HPCS_IDSEL_COUNT; k = k + 1)
		begin
			if (cfg_access && cfg_dev_num == k[DEV_W-1:0] +
				`HPCS_DEV_FIRST)
				id_select_next[k] = 1'b1;
		end
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
			id_select <= {`HPCS_IDSEL_COUNT{1'b0}};
		else
			id_select <= id_select_next;
	end

	// ------------------------------------------------------------------
	// Arbiter
	// ------------------------------------------------------------------
	// Round robin keeps the expansion slot from starving behind the NICs.
	reg [1:0] last_reg;
	reg [`HPCS_REQ_COUNT-1:0] gnt_next;
	reg [1:0] win_next;
	reg found;
	integer i;
	integer idx;
	always @*
	begin
		gnt_next = pci_gnt;
		win_next = last_reg;
		found = 1'b0;
		idx = 0;
		if (pci_gnt != {`HPCS_REQ_COUNT{1'b0}})
		begin
			if ((pci_gnt & pci_req) == {`HPCS_REQ_COUNT{1'b0}})
				gnt_next = {`HPCS_REQ_COUNT{1'b0}};
		end
		else if (pci_bus_idle)
		begin
			for (i = 1; i <= `HPCS_REQ_COUNT; i = i + 1)
			begin
				idx = (last_reg + i) % `HPCS_REQ_COUNT;
				if (!found && pci_req[idx])
				begin
					found = 1'b1;
					gnt_next = {`HPCS_REQ_COUNT{1'b0}};
					gnt_next[idx] = 1'b1;
					win_next = idx[1:0];
				end
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pci_gnt <= {`HPCS_REQ_COUNT{1'b0}};
			last_reg <= 2'h2;
		end
		else
		begin
			pci_gnt <= gnt_next;
			last_reg <= win_next;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt routing
	// ------------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pci_irq_line_a <= 1'b0;
			pci_irq_line_b <= 1'b0;
		end
		else
		begin
			pci_irq_line_a <= home_nic_irq;
			pci_irq_line_b <= fast_nic_irq;
		end
	end

	// ------------------------------------------------------------------
	// Sideband link on shared address pins
	// ------------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_XFER = 2'h2;
	localparam ST_FLOAT = 2'h3;
	reg [1:0] state_reg;
	reg [15:0] cnt_reg;

	// Pins are driven only after the CPU has had its hold for FLOAT_CYC,
	// and released FLOAT_CYC before the hold drops, so outside reset (which clears both in one cycle) the two never fight.
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			cpu_address_hold <= 1'b0;
			sb_addr_oe <= 1'b0;
			sb_addr_out <= {`HPCS_SB_WIDTH{1'b0}};
			sb_rdata <= {`HPCS_SB_WIDTH{1'b0}};
			sb_busy <= 1'b0;
		end
		else
		begin
			case (state_reg)
			ST_IDLE:
			begin
				if (sb_request)
				begin
					cpu_address_hold <= 1'b1;
					sb_busy <= 1'b1;
					cnt_reg <= FLOAT_CYC[15:0];
					state_reg <= ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (cnt_reg > 16'h0001)
					cnt_reg <= cnt_reg - 16'h0001;
				else
				begin
					sb_addr_out <= sb_wdata;
					sb_addr_oe <= sb_write;
					state_reg <= ST_XFER;
				end
			end
			ST_XFER:
			begin
				if (!sb_write)
					sb_rdata <= cpu_addr_in;
				if (sb_done)
				begin
					sb_addr_oe <= 1'b0;
					cnt_reg <= FLOAT_CYC[15:0];
					state_reg <= ST_FLOAT;
				end
			end
			ST_FLOAT:
			begin
				if (cnt_reg > 16'h0001)
					cnt_reg <= cnt_reg - 16'h0001;
				else
				begin
					cpu_address_hold <= 1'b0;
					sb_busy <= 1'b0;
					state_reg <= ST_IDLE;
				end
			end
			default:
				state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// >>> bench/hpcs_properties.sv
`timescale 1ns/1ps
module hpcs_properties (
	input logic clk_sys,
	input logic sys_rst,
	input logic cfg_access,
	input logic [4:0] cfg_dev_num,
	input logic [5:0] id_select,
	input logic [2:0] pci_req,
	input logic [2:0] pci_gnt,
	input logic home_nic_irq,
	input logic pci_irq_line_a,
	input logic sb_request,
	input logic sb_done,
	input logic cpu_address_hold,
	input logic sb_addr_oe,
	input logic sb_busy
);
	wire [4:0] dev_off = cfg_dev_num - 5'h05;
	wire [5:0] dev_sel = dev_off < 5'h06 ? 6'h01 << dev_off : 6'h00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	id_map_a: assert property (cfg_access |=>
		id_select == $past(dev_sel)) else $error("id map");
	id_idle_a: assert property (!cfg_access |=>
		id_select == 6'h00) else $error("id idle");
	gnt_onehot_a: assert property ($onehot0(pci_gnt))
		else $error("gnt onehot");
	gnt_keep_a: assert property (|(pci_gnt & pci_req) |=>
		pci_gnt == $past(pci_gnt)) else $error("gnt keep");
	irq_route_a: assert property (!$past(sys_rst) |->
		pci_irq_line_a == $past(home_nic_irq)) else $error("irq");
	hold_start_a: assert property (sb_request && !sb_busy |=>
		cpu_address_hold) else $error("hold start");
	hold_busy_a: assert property (sb_busy == cpu_address_hold)
		else $error("hold busy");
	done_float_a: assert property (sb_addr_oe && sb_done |=>
		!sb_addr_oe ##1 cpu_address_hold ##1 !cpu_address_hold)
		else $error("float");
	gnt_drop_a: assert property (|pci_gnt && !(|(pci_gnt & pci_req))
		|=> pci_gnt == 3'h0) else $error("gnt drop");
	id_onehot_a: assert property ($onehot0(id_select))
		else $error("id onehot");
	drive_hold_a: assert property ($rose(sb_addr_oe) |->
		$past(cpu_address_hold, 2)) else $error("drive hold");
	release_float_a: assert property ($fell(cpu_address_hold) &&
		!$past(sys_rst) |-> !sb_addr_oe && !$past(sb_addr_oe))
		else $error("release float");
	cover property (cfg_access && id_select != 6'h00);
	cover property ($rose(sb_addr_oe));
	cover property (|pci_gnt);
	cover property ($fell(cpu_address_hold));
endmodule
bind hpcs_top hpcs_properties u_chk (.*);

// >>> bench/hpcs_pci_masters.sv
`timescale 1ns/1ps
module hpcs_pci_masters (
	input logic clk_sys,
	input logic [2:0] want,
	input logic [2:0] pci_gnt,
	output logic [2:0] pci_req
);
	logic [1:0] held [3] = '{2'h0, 2'h0, 2'h0};
	initial pci_req = 3'h0;
	// Without preemption a master must give the bus back itself.
	always @(negedge clk_sys)
	begin
		for (int i = 0; i < 3; i++)
		begin
			held[i] = pci_gnt[i] ? held[i] + 2'h1 : 2'h0;
			pci_req[i] = pci_gnt[i] ? pci_req[i] && held[i] < 2'h2 : want[i];
		end
	end
endmodule

// >>> bench/hpcs_tb_top.sv
`timescale 1ns/1ps
module host_pci_config_select_and_sideband_tb_top;
	logic clk_sys = 1'b0, sys_rst = 1'b1, cfg_access = 1'b0;
	logic home_nic_irq = 1'b0, fast_nic_irq = 1'b0, sb_request = 1'b0;
	logic sb_write = 1'b0, sb_done = 1'b0, pci_bus_idle = 1'b1;
	logic [4:0] cfg_dev_num = 5'h00;
	logic [2:0] want = 3'h0, exp_g, prev_g;
	logic [15:0] sb_wdata = 16'h0000, pin_v = 16'hFFFF;
	logic [31:0] r;
	wire [5:0] id_select;
	wire [2:0] pci_req, pci_gnt;
	wire [15:0] sb_rdata, sb_addr_out;
	wire pci_irq_line_a, pci_irq_line_b, cpu_address_hold, sb_addr_oe, sb_busy;
	wire [15:0] cpu_addr_in = sb_addr_oe ? sb_addr_out : pin_v;
	integer seed = 32'h6b2e, n_errors = 0, cmp_count = 0, k;
	always #12.5 clk_sys = ~clk_sys;
	hpcs_top DUT (.*);
	hpcs_pci_masters u_masters (.clk_sys, .want, .pci_gnt, .pci_req);
	function logic [5:0] idsel_of(input logic [4:0] d);
		return d >= 5'h05 && d <= 5'h0A ? 6'h01 << (d - 5'h05) : 6'h00;
	endfunction
	task check(input logic [15:0] seen, input logic [15:0] exp_v);
		cmp_count++;
		if (seen !== exp_v)
		begin
			n_errors++;
			$display("unexpected at %0t: %h, %h", $time, seen, exp_v);
		end
	endtask
	task results;
		$display("errors %0d of %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	initial
	begin
		tick(4);
		check({cpu_address_hold, sb_addr_oe, sb_busy}, 3'h0);
		sys_rst = 1'b0;
		cfg_access = 1'b1;
		for (k = 0; k < 32; k++)
		begin
			cfg_dev_num = k[4:0];
			tick(1);
			check(id_select, idsel_of(k[4:0]));
		end
		cfg_access = 1'b0;
		want = 3'h7;
		pci_bus_idle = 1'b0;
		tick(1);
		check(id_select, 6'h00);
		exp_g = 3'h1;
		prev_g = 3'h0;
		repeat (40)
		begin
			r = $random(seed);
			{home_nic_irq, fast_nic_irq} = r[1:0];
			pci_bus_idle = |r[3:2];
			tick(1);
			check({pci_irq_line_a, pci_irq_line_b}, r[1:0]);
			if (prev_g === 3'h0)
			begin
				check(pci_gnt, pci_bus_idle ? exp_g : 3'h0);
				if (pci_gnt !== 3'h0)
					exp_g = {exp_g[1:0], exp_g[2]};
			end
			prev_g = pci_gnt;
		end
		want = 3'h0;
		for (k = 0; k < 4; k++)
		begin
			r = $random(seed);
			sb_write = k[0];
			sb_wdata = r[15:0];
			pin_v = ~r[15:0];
			sb_request = 1'b1;
			tick(1);
			sb_request = 1'b0;
			check({sb_busy, cpu_address_hold}, 2'h3);
			tick(2);
			check(sb_addr_oe, k[0]);
			if (k[0])
				check(sb_addr_out, r[15:0]);
			sb_done = 1'b1;
			tick(1);
			sb_done = 1'b0;
			pin_v = r[15:0];
			check({sb_addr_oe, cpu_address_hold}, 2'h1);
			if (!k[0])
				check(sb_rdata, ~r[15:0]);
			tick(1);
			check(cpu_address_hold, 1'b1);
			tick(1);
			check({sb_busy, cpu_address_hold}, 2'h0);
		end
		sb_request = 1'b1;
		tick(3);
		sb_request = 1'b0;
		check(sb_addr_oe, 1'b1);
		sys_rst = 1'b1;
		tick(1);
		check({sb_busy, cpu_address_hold, sb_addr_oe}, 3'h0);
		sys_rst = 1'b0;
		tick(1);
		check(cpu_address_hold, 1'b0);
		results;
	end
endmodule
